// ===== common/rpa_pkg.sv
package rpa_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int LANES = 4;
   localparam int SPACING_W = 16;
   localparam int VIOL_W = 2;
   localparam int TP_W = 8;
   localparam int REP_W = 3;
   localparam logic [REP_W-1:0] REPEAT_LIMIT = 3'h4;

   // ----------------------------------------------------------------
   // Register map, byte addresses on the Wishbone port
   // ----------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] ADDR_SPACING = 8'h04;
   localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADR_W-1:0] ADDR_ALIGN_STAT = 8'h0C;
   localparam logic [ADR_W-1:0] ADDR_PCS_STAT = 8'h10;

   // Control register fields and reset value, spacing reset value
   localparam int CTRL_W = 2;
   localparam int CTRL_TP_EN_BIT = 0;
   localparam int CTRL_SUBLAYER_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;
   localparam logic [SPACING_W-1:0] SPACING_RST = 16'h0FFF;

   // Status register fields
   localparam int STAT_ALIGNED_BIT = 0;
   localparam int STAT_HIBER_BIT = 1;
   localparam int STAT_STATUS_BIT = 2;
   localparam int STAT_ALIGN_ERR_BIT = 3;
   localparam int STAT_REPEAT_LSB = 4;
   localparam int STAT_SPACING_LSB = 8;

   // Management image fields
   localparam int ALIGN_STAT_ALIGNED_BIT = 12;
   localparam int PCS_STAT_HIBER_BIT = 1;
   localparam int PCS_STAT_STATUS_BIT = 12;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic marker_seen;
      logic marker_bad;
      logic bip_bad;
   } rpa_lane_evt_type;

   typedef struct packed {
      logic repeat_err;
      logic word_err;
      logic parity_err;
      logic spacing_err;
      logic misalign;
   } rpa_lane_stat_type;

   typedef enum logic {LANE_NOREF, LANE_TRACK} rpa_lane_state_type;

endpackage

// ===== core/rpa_lane.sv
`timescale 1ns/1ps
`default_nettype none

module rpa_lane
   import rpa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic word_valid_i,
   input wire rpa_lane_evt_type evt_i,
   input wire logic [SPACING_W-1:0] spacing_i,
   input wire logic ever_aligned_i,
   output rpa_lane_stat_type stat_o
);

   rpa_lane_state_type st_r, st_nxt;
   logic [SPACING_W-1:0] gap_r, gap_nxt;
   logic [SPACING_W-1:0] delay_r, delay_nxt;
   logic [REP_W-1:0] rep_r, rep_nxt;
   logic pending_r, pending_nxt;
   rpa_lane_stat_type stat_r, stat_nxt;
   logic bad_seen;
   logic good_seen;

   assign bad_seen = evt_i.marker_seen & evt_i.marker_bad;
   assign good_seen = evt_i.marker_seen & ~evt_i.marker_bad;
   assign stat_o = stat_r;

   // ----------------------------------------------------------------
   // Marker tracking
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      gap_nxt = gap_r;
      delay_nxt = delay_r;
      rep_nxt = rep_r;
      pending_nxt = pending_r;
      stat_nxt = stat_r;
      stat_nxt.word_err = bad_seen;
      stat_nxt.parity_err = evt_i.marker_seen & evt_i.bip_bad;
      stat_nxt.misalign = 1'b0;
      // Marker words are not counted, so a correct gap equals length minus one
      if (evt_i.marker_seen)
      begin
         gap_nxt = '0;
         st_nxt = LANE_TRACK;
         if (st_r == LANE_TRACK)
         begin
            stat_nxt.spacing_err = (gap_r != spacing_i);
         end
      end
      else if (word_valid_i)
      begin
         gap_nxt = gap_r + 16'h0001;
      end
      if (good_seen)
      begin
         rep_nxt = '0;
      end
      else if (bad_seen && rep_r != REPEAT_LIMIT)
      begin
         rep_nxt = rep_r + 3'h1;
      end
      // Flag clears only once a good marker ends the error run
      stat_nxt.repeat_err = (rep_nxt == REPEAT_LIMIT);
      // Report one metaframe later; a fresh error at the deadline re-arms
      if (pending_r && word_valid_i)
      begin
         if (delay_r == '0)
         begin
            stat_nxt.misalign = 1'b1;
            pending_nxt = 1'b0;
         end
         else
         begin
            delay_nxt = delay_r - 16'h0001;
         end
      end
      if (bad_seen && ever_aligned_i)
      begin
         pending_nxt = 1'b1;
         delay_nxt = spacing_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= LANE_NOREF;
         gap_r <= '0;
         delay_r <= '0;
         rep_r <= '0;
         pending_r <= 1'b0;
         stat_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         gap_r <= gap_nxt;
         delay_r <= delay_nxt;
         rep_r <= rep_nxt;
         pending_r <= pending_nxt;
         stat_r <= stat_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   word_err_pulse_a:
      assert property (!$past(rst_i) |-> stat_r.word_err == $past(bad_seen))
      else $error("marker word error pulse mismatch");
   repeat_rise_a:
      assert property ($rose(stat_r.repeat_err) |-> $past(bad_seen) && $past(rep_r) == REPEAT_LIMIT - 3'h1)
      else $error("repeat flag rose without fourth bad marker");
   good_restart_a:
      assert property (good_seen |=> rep_r == '0 && !stat_r.repeat_err)
      else $error("good marker did not restart error run");
   parity_pulse_a:
      assert property (!(evt_i.marker_seen && evt_i.bip_bad) |=> !stat_r.parity_err)
      else $error("parity pulse without cause");
   spacing_check_a:
      assert property (evt_i.marker_seen && st_r == LANE_TRACK && gap_r != spacing_i |=> stat_r.spacing_err)
      else $error("spacing error missed");
   misalign_arm_a:
      assert property (bad_seen && ever_aligned_i |=> pending_r && delay_r == $past(spacing_i) &&
                       stat_r.misalign == $past(pending_r && word_valid_i && delay_r == '0))
      else $error("misalign not deferred by a metaframe");
   misalign_gate_a:
      assert property (stat_r.misalign |-> $past(pending_r) && $past(delay_r) == '0)
      else $error("misalign raised without pending error");

   repeat_seen_c: cover property ($rose(stat_r.repeat_err));

endmodule

`default_nettype wire

// ===== core/rpa_align_status.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Per lane, flag stays high after four bad markers in a row until cleared.
// - Per lane, one-cycle pulse for each malformed lane marker word.
// - One-cycle misalignment pulse when a bad marker is seen on any lane.
// - Misalignment only after lanes aligned once and a bad marker followed.
// - Misalignment pulse comes one metaframe after the causing marker error.
// - Alignment error level while alignment errors exist or alignment was lost.
// - Per lane, one-cycle pulse when the lane parity signature is wrong.
// - All-aligned level high only while every lane is aligned and deskewed.
// - Low all-aligned level is reported as a receive local fault.
// - All-aligned level equals management bit 3.50.12 image.
// - High error rate level mirrors BER monitor and management bit 3.32.1.
// - Sublayer status is aligned and not high error rate.
// - Two-bit increment counts decoder error-state cycles.
// - In sublayer-only mode a qualifier marks the code violation increment valid.
// - Eight-bit one-cycle increment reports test pattern mismatches.
// - Test pattern increment stays zero unless test pattern checking is enabled.
// - In sublayer-only mode a qualifier marks the test pattern increment valid.
// - Per lane, spacing error while markers arrive at the wrong interval.

module rpa_align_status
   import rpa_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic WORD_VALID_I,
   input wire rpa_lane_evt_type [LANES-1:0] LANE_EVT_I,
   input wire logic DESKEW_DONE_I,
   input wire logic HI_BER_I,
   input wire logic [VIOL_W-1:0] DECODE_ERR_I,
   input wire logic [TP_W-1:0] PATTERN_MISMATCH_I,
   output logic [LANES-1:0] LANE_MARKER_REPEAT_ERROR_FLAGS_O,
   output logic [LANES-1:0] LANE_MARKER_WORD_ERROR_PULSES_O,
   output logic [LANES-1:0] LANE_MARKER_SPACING_ERROR_FLAGS_O,
   output logic [LANES-1:0] PARITY_ERROR_PULSES_O,
   output logic MISALIGN_PULSE_O,
   output logic ALIGN_ERROR_O,
   output logic ALL_ALIGNED_O,
   output logic LOCAL_FAULT_O,
   output logic HIGH_ERROR_RATE_FLAG_O,
   output logic SUBLAYER_STATUS_O,
   output logic [VIOL_W-1:0] CODE_VIOL_INC_O,
   output logic CODE_VIOL_VALID_O,
   output logic [TP_W-1:0] PATTERN_MISMATCH_INC_O,
   output logic PATTERN_MISMATCH_VALID_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   rpa_lane_stat_type [LANES-1:0] lane_stat;
   logic [LANES-1:0] lane_misalign;
   logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [SPACING_W-1:0] spacing_r, spacing_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [31:0] rd_data;
   logic wr_take;
   logic aligned_r, aligned_nxt;
   logic fault_r, fault_nxt;
   logic hiber_r, hiber_nxt;
   logic status_r, status_nxt;
   logic align_err_r, align_err_nxt;
   logic ever_r, ever_nxt;
   logic mis_r, mis_nxt;
   logic [VIOL_W-1:0] viol_r, viol_nxt;
   logic viol_v_r, viol_v_nxt;
   logic [TP_W-1:0] tp_r, tp_nxt;
   logic tp_v_r, tp_v_nxt;

   // ----------------------------------------------------------------
   // Lanes
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : gen_lane
         rpa_lane u_lane (
            .clk_i(CLK_SYS_I),
            .rst_i(SYS_RST_I),
            .word_valid_i(WORD_VALID_I),
            .evt_i(LANE_EVT_I[g]),
            .spacing_i(spacing_r),
            .ever_aligned_i(ever_r),
            .stat_o(lane_stat[g])
         );
         assign LANE_MARKER_REPEAT_ERROR_FLAGS_O[g] = lane_stat[g].repeat_err;
         assign LANE_MARKER_WORD_ERROR_PULSES_O[g] = lane_stat[g].word_err;
         assign LANE_MARKER_SPACING_ERROR_FLAGS_O[g] = lane_stat[g].spacing_err;
         assign PARITY_ERROR_PULSES_O[g] = lane_stat[g].parity_err;
         assign lane_misalign[g] = lane_stat[g].misalign;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   // Reads are latched with the ack, so data is one cycle old at most
   always_comb
   begin
      rd_data = '0;
      if (WB_ADR_I == ADDR_CTRL)
      begin
         rd_data[CTRL_W-1:0] = ctrl_r;
      end
      else if (WB_ADR_I == ADDR_SPACING)
      begin
         rd_data[SPACING_W-1:0] = spacing_r;
      end
      else if (WB_ADR_I == ADDR_STATUS)
      begin
         rd_data[STAT_ALIGNED_BIT] = aligned_r;
         rd_data[STAT_HIBER_BIT] = hiber_r;
         rd_data[STAT_STATUS_BIT] = status_r;
         rd_data[STAT_ALIGN_ERR_BIT] = align_err_r;
         rd_data[STAT_REPEAT_LSB +: LANES] = LANE_MARKER_REPEAT_ERROR_FLAGS_O;
         rd_data[STAT_SPACING_LSB +: LANES] = LANE_MARKER_SPACING_ERROR_FLAGS_O;
      end
      else if (WB_ADR_I == ADDR_ALIGN_STAT)
      begin
         rd_data[ALIGN_STAT_ALIGNED_BIT] = aligned_r;
      end
      else if (WB_ADR_I == ADDR_PCS_STAT)
      begin
         rd_data[PCS_STAT_HIBER_BIT] = hiber_r;
         rd_data[PCS_STAT_STATUS_BIT] = status_r;
      end
   end

   assign wr_take = WB_CYC_I & WB_STB_I & WB_WE_I & ack_r;

   always_comb
   begin
      ack_nxt = WB_CYC_I & WB_STB_I & ~ack_r;
      dat_nxt = dat_r;
      ctrl_nxt = ctrl_r;
      spacing_nxt = spacing_r;
      if (ack_nxt)
      begin
         dat_nxt = rd_data;
      end
      // Writes land on the edge where the master sees ack
      if (wr_take && WB_ADR_I == ADDR_CTRL && WB_SEL_I[0])
      begin
         ctrl_nxt = WB_DAT_I[CTRL_W-1:0];
      end
      else if (wr_take && WB_ADR_I == ADDR_SPACING)
      begin
         if (WB_SEL_I[0])
         begin
            spacing_nxt[7:0] = WB_DAT_I[7:0];
         end
         if (WB_SEL_I[1])
         begin
            spacing_nxt[15:8] = WB_DAT_I[15:8];
         end
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SYS_RST_I)
      begin
         ack_r <= 1'b0;
         dat_r <= '0;
         ctrl_r <= CTRL_RST;
         spacing_r <= SPACING_RST;
      end
      else
      begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         ctrl_r <= ctrl_nxt;
         spacing_r <= spacing_nxt;
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

   // ----------------------------------------------------------------
   // Alignment and sublayer status
   // ----------------------------------------------------------------
   always_comb
   begin
      aligned_nxt = DESKEW_DONE_I;
      fault_nxt = ~DESKEW_DONE_I;
      hiber_nxt = HI_BER_I;
      status_nxt = DESKEW_DONE_I & ~HI_BER_I;
      ever_nxt = ever_r | aligned_r;
      // Loss after a first lock counts, as do live lane marker faults
      align_err_nxt = (ever_r & ~DESKEW_DONE_I) | (|LANE_MARKER_REPEAT_ERROR_FLAGS_O) |
                      (|LANE_MARKER_SPACING_ERROR_FLAGS_O);
      mis_nxt = |lane_misalign;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SYS_RST_I)
      begin
         aligned_r <= 1'b0;
         fault_r <= 1'b0;
         hiber_r <= 1'b0;
         status_r <= 1'b0;
         ever_r <= 1'b0;
         align_err_r <= 1'b0;
         mis_r <= 1'b0;
      end
      else
      begin
         aligned_r <= aligned_nxt;
         fault_r <= fault_nxt;
         hiber_r <= hiber_nxt;
         status_r <= status_nxt;
         ever_r <= ever_nxt;
         align_err_r <= align_err_nxt;
         mis_r <= mis_nxt;
      end
   end

   assign ALL_ALIGNED_O = aligned_r;
   assign LOCAL_FAULT_O = fault_r;
   assign HIGH_ERROR_RATE_FLAG_O = hiber_r;
   assign SUBLAYER_STATUS_O = status_r;
   assign ALIGN_ERROR_O = align_err_r;
   assign MISALIGN_PULSE_O = mis_r;

   // ----------------------------------------------------------------
   // Increments
   // ----------------------------------------------------------------
   always_comb
   begin
      viol_nxt = {1'b0, DECODE_ERR_I[0]} + {1'b0, DECODE_ERR_I[1]};
      viol_v_nxt = ctrl_r[CTRL_SUBLAYER_BIT];
      tp_nxt = ctrl_r[CTRL_TP_EN_BIT] ? PATTERN_MISMATCH_I : '0;
      tp_v_nxt = ctrl_r[CTRL_SUBLAYER_BIT] & ctrl_r[CTRL_TP_EN_BIT];
   end

   // Each cycle holds a fresh increment, so a count never repeats
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SYS_RST_I)
      begin
         viol_r <= '0;
         viol_v_r <= 1'b0;
         tp_r <= '0;
         tp_v_r <= 1'b0;
      end
      else
      begin
         viol_r <= viol_nxt;
         viol_v_r <= viol_v_nxt;
         tp_r <= tp_nxt;
         tp_v_r <= tp_v_nxt;
      end
   end

   assign CODE_VIOL_INC_O = viol_r;
   assign CODE_VIOL_VALID_O = viol_v_r;
   assign PATTERN_MISMATCH_INC_O = tp_r;
   assign PATTERN_MISMATCH_VALID_O = tp_v_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   aligned_follow_a:
      assert property (!$past(SYS_RST_I) |-> ALL_ALIGNED_O == $past(DESKEW_DONE_I))
      else $error("all-aligned does not follow deskew");
   local_fault_a:
      assert property (!$past(SYS_RST_I) |-> LOCAL_FAULT_O == !ALL_ALIGNED_O)
      else $error("local fault not inverse of aligned");
   align_image_a:
      assert property (ack_r && !WB_WE_I && $past(WB_ADR_I) == ADDR_ALIGN_STAT |->
                       WB_DAT_O[ALIGN_STAT_ALIGNED_BIT] == $past(ALL_ALIGNED_O))
      else $error("alignment image mismatch");
   hiber_follow_a:
      assert property (!$past(SYS_RST_I) |-> HIGH_ERROR_RATE_FLAG_O == $past(HI_BER_I))
      else $error("high error rate flag mismatch");
   status_combine_a:
      assert property (!$past(SYS_RST_I) |-> SUBLAYER_STATUS_O == (ALL_ALIGNED_O && !HIGH_ERROR_RATE_FLAG_O))
      else $error("sublayer status mismatch");
   status_image_a:
      assert property (ack_r && !WB_WE_I && $past(WB_ADR_I) == ADDR_PCS_STAT |->
                       WB_DAT_O[PCS_STAT_STATUS_BIT] == $past(SUBLAYER_STATUS_O))
      else $error("status image mismatch");
   viol_count_a:
      assert property (!$past(SYS_RST_I) |->
                       CODE_VIOL_INC_O == $past({1'b0, DECODE_ERR_I[0]} + {1'b0, DECODE_ERR_I[1]}))
      else $error("code violation increment wrong");
   viol_valid_a:
      assert property (!$past(SYS_RST_I) |-> CODE_VIOL_VALID_O == $past(ctrl_r[CTRL_SUBLAYER_BIT]))
      else $error("code violation qualifier wrong");
   tp_gate_a:
      assert property (!$past(ctrl_r[CTRL_TP_EN_BIT]) |-> PATTERN_MISMATCH_INC_O == '0 && !PATTERN_MISMATCH_VALID_O)
      else $error("test pattern increment active while disabled");
   tp_pass_a:
      assert property ($past(ctrl_r[CTRL_TP_EN_BIT]) && !$past(SYS_RST_I) |->
                       PATTERN_MISMATCH_INC_O == $past(PATTERN_MISMATCH_I))
      else $error("test pattern increment wrong");
   misalign_ever_a:
      assert property (MISALIGN_PULSE_O |-> ever_r)
      else $error("misalign before first alignment");
   align_err_a:
      assert property (ever_r && !DESKEW_DONE_I |=> ALIGN_ERROR_O)
      else $error("alignment loss not flagged");
   wb_ack_a:
      assert property (ack_r |=> !ack_r)
      else $error("ack held longer than one cycle");

   misalign_c: cover property (MISALIGN_PULSE_O);
   status_up_c: cover property ($rose(SUBLAYER_STATUS_O));
   tp_hit_c: cover property (PATTERN_MISMATCH_INC_O != '0);
   wb_write_c: cover property (wr_take && WB_ADR_I == ADDR_SPACING);

endmodule

`default_nettype wire

// ===== test/rpa_stat_sink.sv
`timescale 1ns/1ps
`default_nettype none

module rpa_stat_sink
   import rpa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [VIOL_W-1:0] viol_inc_i,
   input wire logic viol_vld_i,
   input wire logic [TP_W-1:0] tp_inc_i,
   input wire logic tp_vld_i,
   output logic [15:0] viol_sum_o,
   output logic [15:0] tp_sum_o
);
   // ----------------------------------------------------------------
   // Accumulators
   // ----------------------------------------------------------------
   // Increments without their valid qualifier are never added
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         viol_sum_o <= 16'h0000;
         tp_sum_o <= 16'h0000;
      end
      else
      begin
         if (viol_vld_i)
            viol_sum_o <= viol_sum_o + 16'(viol_inc_i);
         if (tp_vld_i)
            tp_sum_o <= tp_sum_o + 16'(tp_inc_i);
      end
   end
endmodule

`default_nettype wire

// ===== test/rpa_align_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rpa_align_status_tb
   import rpa_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dsk = 1'b0, hb = 1'b0, wv = 1'b1;
   logic [7:0] adr = 8'h00, pm = 8'h00;
   logic [31:0] wd = 32'h0, q, rd;
   rpa_lane_evt_type [LANES-1:0] evt = '0;
   logic [1:0] de = 2'h0, cvi;
   logic [3:0] rep, wer, spe, par;
   logic ack, mis, aerr, algn, lf, hber, st, cvv, tpv, mis1;
   logic [7:0] tpi;
   logic [15:0] vs, ts;
   int bad_count = 0, compares = 0, mis_n = 0, i;

   rpa_align_status uut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
      .WORD_VALID_I(wv), .LANE_EVT_I(evt), .DESKEW_DONE_I(dsk), .HI_BER_I(hb), .DECODE_ERR_I(de),
      .PATTERN_MISMATCH_I(pm), .LANE_MARKER_REPEAT_ERROR_FLAGS_O(rep),
      .LANE_MARKER_WORD_ERROR_PULSES_O(wer), .LANE_MARKER_SPACING_ERROR_FLAGS_O(spe),
      .PARITY_ERROR_PULSES_O(par), .MISALIGN_PULSE_O(mis), .ALIGN_ERROR_O(aerr),
      .ALL_ALIGNED_O(algn), .LOCAL_FAULT_O(lf), .HIGH_ERROR_RATE_FLAG_O(hber),
      .SUBLAYER_STATUS_O(st), .CODE_VIOL_INC_O(cvi), .CODE_VIOL_VALID_O(cvv),
      .PATTERN_MISMATCH_INC_O(tpi), .PATTERN_MISMATCH_VALID_O(tpv));

   rpa_stat_sink sink (.clk_i(clk), .rst_i(rst), .viol_inc_i(cvi), .viol_vld_i(cvv),
      .tp_inc_i(tpi), .tp_vld_i(tpv), .viol_sum_o(vs), .tp_sum_o(ts));

   always #10 clk = ~clk;

   always @(posedge clk)
      if (mis === 1'b1)
         mis_n++;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task summarize();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
      begin
         bad_count++;
         $display("[FAIL] wb_ack expected 1 seen 0");
      end
   endtask

   // Marker on every lane, then gap plain words
   task mk(input logic [3:0] bd, input logic [3:0] bp, input int gap);
      int l;
      @(posedge clk);
      for (l = 0; l < LANES; l++)
         evt[l] <= '{1'b1, bd[l], bp[l]};
      @(posedge clk);
      evt <= '0;
      #1;
      chk("word_err", 32'(bd), 32'(wer));
      chk("parity", 32'(bp), 32'(par));
      @(posedge clk);
      #1;
      mis1 = mis;
      chk("pulse_end", 0, 32'(wer | par));
      repeat (gap - 2) @(posedge clk);
   endtask

   task wait2();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("fault", 1, 32'(lf));
      wb(0, ADDR_CTRL, 0, q);
      chk("ctrl", 32'(CTRL_RST), q);
      wb(0, ADDR_SPACING, 0, q);
      chk("spacing", 32'(SPACING_RST), q);
      wb(0, 8'h40, 0, q);
      chk("unmapped", 0, q);
      wb(1, ADDR_SPACING, 32'h3, q);
      wb(1, ADDR_CTRL, 32'h3, q);
      mk(4'h0, 4'h0, 3);
      mk(4'h2, 4'h0, 3);
      mk(4'h0, 4'h0, 3);
      #1;
      chk("misalign_count", 0, 32'(mis_n));
      @(posedge clk);
      dsk <= 1'b1;
      wait2();
      chk("aligned", 1, 32'(algn));
      chk("fault", 0, 32'(lf));
      chk("status", 1, 32'(st));
      wb(0, ADDR_ALIGN_STAT, 0, q);
      chk("align_img", 32'h1000, q);
      wb(0, ADDR_PCS_STAT, 0, q);
      chk("pcs_img", 32'h1000, q);
      mk(4'h0, 4'h0, 3);
      mk(4'h2, 4'h0, 3);
      chk("misalign_early", 0, 32'(mis1));
      mk(4'h0, 4'h0, 3);
      chk("misalign", 1, 32'(mis1));
      #1;
      chk("misalign_once", 32'h1, 32'(mis_n));
      for (i = 1; i <= 4; i++)
      begin
         mk(4'h4, 4'h0, 3);
         chk("repeat", (i == 4) ? 32'h4 : 32'h0, 32'(rep));
      end
      chk("align_err", 1, 32'(aerr));
      mk(4'h0, 4'h0, 3);
      chk("repeat_clr", 0, 32'(rep));
      mk(4'h0, 4'h0, 2);
      mk(4'h0, 4'h0, 3);
      chk("spacing_err", 32'hF, 32'(spe));
      mk(4'h0, 4'h9, 3);
      chk("spacing_clr", 0, 32'(spe));
      chk("align_err", 0, 32'(aerr));
      // One idle word in the gap must not be counted
      wv <= 1'b0;
      @(posedge clk);
      wv <= 1'b1;
      mk(4'h0, 4'h0, 3);
      chk("spacing_skip", 32'h0, 32'(spe));
      hb <= 1'b1;
      wait2();
      chk("hiber", 1, 32'(hber));
      chk("status", 0, 32'(st));
      wb(0, ADDR_PCS_STAT, 0, q);
      chk("pcs_img", 32'h2, q);
      hb <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         de <= 2'(i);
         @(posedge clk);
         de <= 2'h0;
         #1;
         chk("viol_inc", 32'(i % 2 + i / 2), 32'(cvi));
         chk("viol_vld", 1, 32'(cvv));
      end
      wait2();
      chk("viol_sum", 4, 32'(vs));
      @(posedge clk);
      pm <= 8'h5A;
      @(posedge clk);
      pm <= 8'h00;
      #1;
      chk("tp_inc", 32'h5A, 32'(tpi));
      chk("tp_vld", 1, 32'(tpv));
      wb(1, ADDR_CTRL, 32'h2, q);
      pm <= 8'h33;
      @(posedge clk);
      pm <= 8'h00;
      #1;
      chk("tp_off", 0, 32'(tpi));
      chk("tp_vld_off", 0, 32'(tpv));
      chk("tp_sum", 32'h5A, 32'(ts));
      @(posedge clk);
      dsk <= 1'b0;
      hb <= 1'b1;
      wait2();
      chk("loss", 1, 32'(aerr & lf & ~algn));
      wb(0, ADDR_STATUS, 0, q);
      chk("status_reg", 32'((1 << STAT_HIBER_BIT) | (1 << STAT_ALIGN_ERR_BIT)), q);
      rst <= 1'b1;
      wait2();
      chk("in_reset", 0, 32'({hber, lf, aerr}));
      summarize();
   end

   initial
   begin
      #100000;
      bad_count++;
      summarize();
   end
endmodule

`default_nettype wire
